// [lspc_pkg.sv]
// constants and carrier types for the led sink protection control block
package lspc_pkg;

	localparam int unsigned CHANNELS        = 3;
	localparam int unsigned CLK_HZ          = 50_000_000;

	// times as printed
	localparam int unsigned ON_MIN_NS       = 10_000;
	localparam int unsigned SOFT_START_US   = 200;
	localparam int unsigned STANDBY_MS      = 4;
	localparam int unsigned DEGLITCH_MS     = 3;
	localparam int unsigned HICCUP_MS       = 128;
	localparam int unsigned DEGLITCH_PULSES = 7;

	// cycle counts derived from the clock rate
	localparam int unsigned ON_MIN_CYCLES   = (ON_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned SS_CYCLES       = SOFT_START_US * (CLK_HZ / 1_000_000);
	localparam int unsigned STANDBY_CYCLES  = STANDBY_MS * (CLK_HZ / 1000);
	localparam int unsigned DEGLITCH_CYCLES = DEGLITCH_MS * (CLK_HZ / 1000);
	localparam int unsigned HICCUP_CYCLES   = HICCUP_MS * (CLK_HZ / 1000);
	localparam int unsigned RETEST_CYCLES   = 2 * ON_MIN_CYCLES;

	// current reference scale
	localparam int unsigned LEVEL_W         = 8;
	localparam logic [7:0]  LEVEL_FULL      = 8'hff;
	localparam logic [7:0]  FOLD_STEP       = 8'h10;
	localparam int unsigned FOLD_W          = 4;

	// digitised comparator outputs from the analogue front end
	typedef struct packed {
		logic              supply_above_on;
		logic              supply_above_off;
		logic              supply_above_short;
		logic              temp_above_fold;
		logic              temp_above_shut;
		logic              temp_above_recover;
		logic [FOLD_W-1:0] fold_steps;
	} lspc_sense_type;

	typedef enum logic [1:0] {
		LSPC_RUN    = 2'b00,
		LSPC_SHUT   = 2'b01,
		LSPC_RETEST = 2'b10
	} lspc_prot_type;

endpackage : lspc_pkg

// [lspc_fault_deglitch.sv]
// per channel fault deglitch: pulse count or full duty timer
module lspc_fault_deglitch #(
	parameter int unsigned DEG_CYCLES = lspc_pkg::DEGLITCH_CYCLES,
	parameter int unsigned ON_MIN     = lspc_pkg::ON_MIN_CYCLES,
	parameter int unsigned PULSES     = lspc_pkg::DEGLITCH_PULSES
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// control
	input  wire logic clear,
	input  wire logic enable,
	// monitored signals
	input  wire logic dim,
	input  wire logic condition,
	// result
	output logic      confirmed
);
	import lspc_pkg::*;

	localparam int unsigned ON_W  = $clog2(ON_MIN + 1);
	localparam int unsigned DEG_W = $clog2(DEG_CYCLES + 1);
	localparam logic [ON_W-1:0]  ON_LIM    = ON_W'(ON_MIN);
	localparam logic [DEG_W-1:0] DEG_LIM   = DEG_W'(DEG_CYCLES);
	localparam logic [3:0]       PULSE_LIM = 4'(PULSES);

	logic             dim_q;
	logic [ON_W-1:0]  on_cnt;
	logic [DEG_W-1:0] ms_cnt;
	logic [3:0]       pulse_cnt;
	logic             seen;
	logic             qual;
	logic             hit;
	logic             miss;
	logic             fall;

	// short pulses are never judged: the sensing has not settled
	assign qual = dim && (on_cnt >= ON_LIM);
	assign hit  = qual && enable && condition;
	assign miss = qual && !(enable && condition);
	assign fall = dim_q && !dim;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dim_q  <= 1'b0;
			on_cnt <= '0;
		end else begin
			dim_q  <= dim;
			if (!dim)
				on_cnt <= '0;
			else if (on_cnt < ON_LIM)
				on_cnt <= on_cnt + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			seen <= 1'b0;
		else if (fall)
			seen <= 1'b0;
		else if (hit)
			seen <= 1'b1;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			pulse_cnt <= '0;
		else if (clear || miss)
			pulse_cnt <= '0;
		else if (fall && seen && pulse_cnt < PULSE_LIM)
			pulse_cnt <= pulse_cnt + 1'b1;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			ms_cnt <= '0;
		else if (clear || !hit)
			ms_cnt <= '0;
		else if (ms_cnt < DEG_LIM)
			ms_cnt <= ms_cnt + 1'b1;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			confirmed <= 1'b0;
		else if (clear)
			confirmed <= 1'b0;
		else
			confirmed <= (pulse_cnt == PULSE_LIM) || (ms_cnt == DEG_LIM);
	end

	a_pulse_clears: assert property (@(posedge clk) disable iff (!reset_n)
		miss && !clear |=> pulse_cnt == 4'h0 && ms_cnt == '0)
		else $error("deglitch counters not cleared on missing condition");

	a_confirm_cause: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(confirmed) |-> $past(pulse_cnt) == PULSE_LIM || $past(ms_cnt) == DEG_LIM)
		else $error("fault confirmed without full deglitch count");

	a_short_pulse_ignored: assert property (@(posedge clk) disable iff (!reset_n)
		dim && on_cnt < ON_LIM |=> ms_cnt == '0 && !seen)
		else $error("condition judged during too short on-time");

endmodule : lspc_fault_deglitch

// [lspc_protect_core.sv]
// led sink gating, soft start, standby and protection control
// Summary of operation
// - a channel's sink is on while its dim input is high, off while low.
// - device is enabled if any dim input is high, disabled when all low.
// - with an input high and supply good, current ramps over 200 us.
// - all inputs low for more than 4 ms enters standby.
// - any dim activity leaves standby with no other command.
// - faults pull the open-drain fault line low; never driven high.
// - off until supply above 6 V; off and fault below about 5.7 V.
// - open string for 7 dim cycles or 3 ms full duty shuts all channels.
// - after open shutdown retest every 128 ms, resume when cleared.
// - open detection only counts when on-time exceeds 10 us.
// - fault line held low while open or short persists, then released.
// - pin above 15 V for 7 cycles or 3 ms shuts all channels.
// - after short shutdown recheck every 128 ms, resume when cleared.
// - short detection needs supply above 15 V and on-time over 10 us.
// - above 130 C the current reference folds back with temperature.
// - at 160 C stop all sinks and fault; below 140 C soft-start again.
module lspc_protect_core #(
	parameter int unsigned SS_CYCLES       = lspc_pkg::SS_CYCLES,
	parameter int unsigned STANDBY_CYCLES  = lspc_pkg::STANDBY_CYCLES,
	parameter int unsigned DEGLITCH_CYCLES = lspc_pkg::DEGLITCH_CYCLES,
	parameter int unsigned HICCUP_CYCLES   = lspc_pkg::HICCUP_CYCLES
) (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   reset_n,
	// host dimming inputs
	input  wire logic [2:0]             channel_dim_inputs,
	// analogue front end
	input  wire lspc_pkg::lspc_sense_type sense,
	input  wire logic [2:0]             channel_open_detect,
	input  wire logic [2:0]             channel_pin_high,
	// current sinks
	output logic [2:0]                  channel_sink_outputs,
	output logic [7:0]                  current_level,
	output logic                        standby,
	// open-drain fault line
	output logic                        shared_fault_line_n_out,
	output logic                        shared_fault_line_n_oe
);
	import lspc_pkg::*;

	localparam int unsigned SS_STEP  = (SS_CYCLES / 255 > 0) ? SS_CYCLES / 255 : 1;
	localparam int unsigned SS_W     = $clog2(SS_STEP + 1);
	localparam int unsigned SB_W     = $clog2(STANDBY_CYCLES + 1);
	localparam int unsigned HC_W     = $clog2(HICCUP_CYCLES + 1);
	localparam int unsigned RT_W     = $clog2(RETEST_CYCLES + 1);
	localparam logic [SS_W-1:0] SS_LIM = SS_W'(SS_STEP - 1);
	localparam logic [SB_W-1:0] SB_LIM = SB_W'(STANDBY_CYCLES);
	localparam logic [HC_W-1:0] HC_LIM = HC_W'(HICCUP_CYCLES - 1);
	localparam logic [RT_W-1:0] RT_LIM = RT_W'(RETEST_CYCLES - 1);
	localparam int STBY_WAIT = 2;

	logic             supply_ok;
	logic             thermal_shut;
	logic [SB_W-1:0]  idle_cnt;
	logic [SS_W-1:0]  ss_div;
	logic [7:0]       ramp_level;
	lspc_prot_type    prot_state;
	logic [2:0]       faulty_open;
	logic [2:0]       faulty_short;
	logic [HC_W-1:0]  hiccup_cnt;
	logic [RT_W-1:0]  retest_cnt;
	logic [2:0]       conf_open;
	logic [2:0]       conf_short;
	logic             any_active;
	logic             prot_shut;
	logic             run_ok;
	logic             ramp_go;
	logic             new_fault;
	logic             still_bad;
	logic             fault_req;
	logic [2:0]       next_sink;
	logic [7:0]       next_level;
	logic [11:0]      fold_drop;

	assign any_active = |channel_dim_inputs;
	assign prot_shut  = (prot_state != LSPC_RUN);
	assign run_ok     = supply_ok && !thermal_shut && !prot_shut;
	assign ramp_go    = run_ok && !standby;
	assign new_fault  = |{conf_open, conf_short};

	// supply lockout with hysteresis from two comparators
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			supply_ok <= 1'b0;
		else if (!sense.supply_above_off)
			supply_ok <= 1'b0;
		else if (sense.supply_above_on)
			supply_ok <= 1'b1;
	end

	// thermal shutdown with recovery hysteresis
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			thermal_shut <= 1'b0;
		else if (sense.temp_above_shut)
			thermal_shut <= 1'b1;
		else if (!sense.temp_above_recover)
			thermal_shut <= 1'b0;
	end

	// standby entry after a long idle stretch, exit on any activity
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			idle_cnt <= '0;
			standby  <= 1'b1;
		end else if (any_active) begin
			idle_cnt <= '0;
			standby  <= 1'b0;
		end else if (idle_cnt < SB_LIM) begin
			idle_cnt <= idle_cnt + 1'b1;
		end else begin
			standby  <= 1'b1;
		end
	end

	// soft start ramp; a fresh ramp after every shutdown or standby
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ss_div     <= '0;
			ramp_level <= 8'h00;
		end else if (!ramp_go) begin
			ss_div     <= '0;
			ramp_level <= 8'h00;
		end else if (ramp_level != LEVEL_FULL) begin
			if (ss_div == SS_LIM) begin
				ss_div     <= '0;
				ramp_level <= ramp_level + 8'h01;
			end else begin
				ss_div <= ss_div + 1'b1;
			end
		end
	end

	// foldback lowers the reference, saturating at zero
	always_comb begin
		fold_drop = 12'(sense.fold_steps) * 12'(FOLD_STEP);
		if (!sense.temp_above_fold)
			next_level = ramp_level;
		else if (fold_drop >= 12'(ramp_level))
			next_level = 8'h00;
		else
			next_level = ramp_level - fold_drop[7:0];
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			current_level <= 8'h00;
		else
			current_level <= next_level;
	end

	// deglitch per channel for open and short strings
	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
			lspc_fault_deglitch #(
				.DEG_CYCLES (DEGLITCH_CYCLES),
				.ON_MIN     (ON_MIN_CYCLES),
				.PULSES     (DEGLITCH_PULSES)
			) u_open (
				.clk       (clk),
				.reset_n   (reset_n),
				.clear     (prot_shut),
				.enable    (run_ok),
				.dim       (channel_dim_inputs[ch]),
				.condition (channel_open_detect[ch]),
				.confirmed (conf_open[ch])
			);
			lspc_fault_deglitch #(
				.DEG_CYCLES (DEGLITCH_CYCLES),
				.ON_MIN     (ON_MIN_CYCLES),
				.PULSES     (DEGLITCH_PULSES)
			) u_short (
				.clk       (clk),
				.reset_n   (reset_n),
				.clear     (prot_shut),
				.enable    (run_ok && sense.supply_above_short),
				.dim       (channel_dim_inputs[ch]),
				.condition (channel_pin_high[ch]),
				.confirmed (conf_short[ch])
			);
		end
	endgenerate

	// retest looks only at the channels that tripped
	assign still_bad = |(faulty_open & channel_open_detect) ||
		(sense.supply_above_short && |(faulty_short & channel_pin_high));

	// hiccup protection state
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prot_state <= LSPC_RUN;
		end else begin
			case (prot_state)
				LSPC_RUN: begin
					if (new_fault)
						prot_state <= LSPC_SHUT;
				end
				LSPC_SHUT: begin
					if (hiccup_cnt == HC_LIM)
						prot_state <= LSPC_RETEST;
				end
				LSPC_RETEST: begin
					if (retest_cnt == RT_LIM)
						prot_state <= still_bad ? LSPC_SHUT : LSPC_RUN;
				end
				default: prot_state <= LSPC_RUN;
			endcase
		end
	end

	// tripped channels, a new trip wins over the release
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			faulty_open  <= 3'h0;
			faulty_short <= 3'h0;
		end else if (new_fault) begin
			faulty_open  <= faulty_open | conf_open;
			faulty_short <= faulty_short | conf_short;
		end else if (prot_state == LSPC_RETEST && retest_cnt == RT_LIM && !still_bad) begin
			faulty_open  <= 3'h0;
			faulty_short <= 3'h0;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			hiccup_cnt <= '0;
		else if (prot_state != LSPC_SHUT)
			hiccup_cnt <= '0;
		else
			hiccup_cnt <= hiccup_cnt + 1'b1;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			retest_cnt <= '0;
		else if (prot_state != LSPC_RETEST)
			retest_cnt <= '0;
		else
			retest_cnt <= retest_cnt + 1'b1;
	end

	// sink gating; retest briefly drives only the tripped channels
	always_comb begin
		next_sink = 3'h0;
		if (run_ok)
			next_sink = channel_dim_inputs;
		else if (prot_state == LSPC_RETEST && supply_ok && !thermal_shut)
			next_sink = faulty_open | faulty_short;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			channel_sink_outputs <= 3'h0;
		else
			channel_sink_outputs <= next_sink;
	end

	// the line is only ever pulled low; the pull-up is off chip
	assign fault_req = !supply_ok || thermal_shut || prot_shut;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			shared_fault_line_n_out <= 1'b0;
			shared_fault_line_n_oe  <= 1'b0;
		end else begin
			shared_fault_line_n_out <= 1'b0;
			shared_fault_line_n_oe  <= fault_req;
		end
	end

	a_sink_follows_dim: assert property (@(posedge clk) disable iff (!reset_n)
		run_ok |=> channel_sink_outputs == $past(channel_dim_inputs))
		else $error("sink does not follow dim input");

	a_any_input_wakes: assert property (@(posedge clk) disable iff (!reset_n)
		any_active |=> !standby)
		else $error("standby not left on dim activity");

	a_standby_needs_idle: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(standby) |-> $past(idle_cnt) == SB_LIM && !$past(any_active))
		else $error("standby entered before idle time elapsed");

	a_ramp_from_zero: assert property (@(posedge clk) disable iff (!reset_n)
		!ramp_go ##1 ramp_go |-> ramp_level == 8'h00 ##1 ramp_level <= 8'h01)
		else $error("soft start does not begin at zero");

	a_fault_drives_low: assert property (@(posedge clk) disable iff (!reset_n)
		fault_req |=> shared_fault_line_n_oe && !shared_fault_line_n_out)
		else $error("fault request not shown on fault line");

	a_supply_low_lockout_off: assert property (@(posedge clk) disable iff (!reset_n)
		!sense.supply_above_off |=> ##1 channel_sink_outputs == 3'h0)
		else $error("sinks on under supply lockout");

	a_trip_shuts_all: assert property (@(posedge clk) disable iff (!reset_n)
		prot_state == LSPC_RUN && new_fault |=> ##1 channel_sink_outputs == 3'h0)
		else $error("string fault did not shut all channels");

	a_hot_shutdown: assert property (@(posedge clk) disable iff (!reset_n)
		sense.temp_above_shut |=> ##1 channel_sink_outputs == 3'h0 && shared_fault_line_n_oe)
		else $error("thermal shutdown not applied");

	a_hiccup_period: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(prot_state == LSPC_RETEST) |-> $past(hiccup_cnt) == HC_LIM)
		else $error("retest outside hiccup period");

	a_fold_lowers: assert property (@(posedge clk) disable iff (!reset_n)
		sense.temp_above_fold && sense.fold_steps != '0 && ramp_level != 8'h00
		|=> current_level < $past(ramp_level))
		else $error("foldback did not lower reference");

	a_standby_soon: assert property (@(posedge clk) disable iff (!reset_n)
		!any_active && idle_cnt == SB_LIM |-> ##[1:STBY_WAIT] standby)
		else $error("standby not entered after idle time");

	a_retest_release: assert property (@(posedge clk) disable iff (!reset_n)
		prot_state == LSPC_RETEST && retest_cnt == RT_LIM && !still_bad
		|=> prot_state == LSPC_RUN && faulty_open == 3'h0 && faulty_short == 3'h0)
		else $error("passed retest did not release the driver");

	a_shut_holds_line: assert property (@(posedge clk) disable iff (!reset_n)
		prot_state != LSPC_RUN |=> shared_fault_line_n_oe)
		else $error("fault line released during string shutdown");

	a_line_released: assert property (@(posedge clk) disable iff (!reset_n)
		!fault_req |=> !shared_fault_line_n_oe)
		else $error("fault line held with no active condition");

	c_string_trip: cover property (@(posedge clk) disable iff (!reset_n) $rose(prot_shut));
	c_standby_entry: cover property (@(posedge clk) disable iff (!reset_n) $rose(standby));
	c_ramp_full: cover property (@(posedge clk) disable iff (!reset_n) ramp_level == LEVEL_FULL);
	c_retest_clear: cover property (@(posedge clk) disable iff (!reset_n)
		prot_state == LSPC_RETEST ##1 prot_state == LSPC_RUN);
	c_thermal_trip: cover property (@(posedge clk) disable iff (!reset_n) $rose(thermal_shut));

endmodule : lspc_protect_core

// [lspc_host_model.sv]
// host model: dim waveform generator and pulled-up shared fault line
module lspc_host_model (
	// clock
	input  wire logic       clk,
	// waveform control
	input  wire logic       pulse_en,
	input  wire logic [2:0] level,
	input  wire logic [2:0] mask,
	// device side
	output logic [2:0]      dim,
	input  wire logic       fault_out,
	input  wire logic       fault_oe,
	output logic            fault_line,
	output int              pulses
);
	timeunit 1ns;
	timeprecision 1ps;
	// 600 high in 1000 cycles: 12 us pulses at 50 kHz
	localparam int HI  = 600;
	localparam int PER = 1000;
	int ph;
	// one external pull-up, any driver pulls low
	assign fault_line = fault_oe ? fault_out : 1'b1;
	initial begin
		dim = 3'h0;
		ph = 0;
		pulses = 0;
	end
	always @(negedge clk) begin
		if (!pulse_en) begin
			dim <= level;
			ph <= 0;
			pulses <= 0;
		end else begin
			dim <= (ph < HI) ? mask : 3'h0;
			if (ph == HI)
				pulses <= pulses + 1;
			ph <= (ph == PER - 1) ? 0 : ph + 1;
		end
	end
endmodule : lspc_host_model

// [lspc_bench.sv]
// self-checking bench for the led sink protection control block
module lspc_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import lspc_pkg::*;
	logic           clk;
	logic           reset_n;
	logic           pulse_en;
	logic [2:0]     dim_level;
	logic [2:0]     dim_mask;
	logic [2:0]     dim;
	lspc_sense_type sense;
	logic [2:0]     open_det;
	logic [2:0]     pin_hi;
	logic [2:0]     sinks;
	logic [7:0]     level;
	logic           standby;
	logic           f_out;
	logic           f_oe;
	logic           fault_line;
	int             pulses;
	int             n_fail;
	int             num_checks;
	// rows: dim pattern, expected sinks, expected standby
	localparam logic [6:0] ROWS [9] = '{7'h01, 7'h12, 7'h24, 7'h36, 7'h48,
		7'h5a, 7'h6c, 7'h7e, 7'h00};

	// shortened counts keep the run short
	lspc_protect_core #(.SS_CYCLES(510), .STANDBY_CYCLES(200),
		.DEGLITCH_CYCLES(300), .HICCUP_CYCLES(2000)) dut (
		.clk(clk), .reset_n(reset_n), .channel_dim_inputs(dim),
		.sense(sense), .channel_open_detect(open_det), .channel_pin_high(pin_hi),
		.channel_sink_outputs(sinks), .current_level(level), .standby(standby),
		.shared_fault_line_n_out(f_out), .shared_fault_line_n_oe(f_oe));
	lspc_host_model host (.clk(clk), .pulse_en(pulse_en), .level(dim_level),
		.mask(dim_mask), .dim(dim), .fault_out(f_out), .fault_oe(f_oe),
		.fault_line(fault_line), .pulses(pulses));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask : idle

	task automatic wait_line(input logic v, input int bound);
		int i;
		for (i = 0; i < bound && fault_line !== v; i++)
			@(negedge clk);
		check({7'h0, fault_line}, {7'h0, v});
		if (fault_line !== v)
			close_out();
	endtask : wait_line

	task automatic wait_level(input logic [7:0] v, input int bound);
		int i;
		for (i = 0; i < bound && level !== v; i++)
			@(negedge clk);
		check(level, v);
		if (level !== v)
			close_out();
	endtask : wait_level

	task automatic wait_pulses(input int n);
		int i;
		for (i = 0; i < 20000 && pulses < n; i++)
			@(negedge clk);
		if (pulses < n) begin
			check(8'h0, 8'h1);
			close_out();
		end
	endtask : wait_pulses

	initial begin
		pulse_en = 1'b0;
		dim_level = 3'h0;
		dim_mask = 3'h0;
		sense = '0;
		open_det = 3'h0;
		pin_hi = 3'h0;
		reset_n = 1'b0;
		n_fail = 0;
		num_checks = 0;
		sense.supply_above_on = 1'b1;
		sense.supply_above_off = 1'b1;
		idle(5);
		check({5'h0, sinks}, 8'h00);
		check({6'h0, standby, f_oe}, 8'h02);
		reset_n = 1'b1;
		idle(3);
		check({7'h0, fault_line}, 8'h01);
		for (int i = 0; i < 9; i++) begin
			dim_level = ROWS[i][6:4];
			idle(2);
			check({5'h0, sinks}, {5'h0, ROWS[i][3:1]});
			check({7'h0, standby}, {7'h0, ROWS[i][0]});
		end
		// thermal shutdown with hysteresis, then a fresh ramp
		dim_level = 3'h7;
		sense.temp_above_shut = 1'b1;
		sense.temp_above_recover = 1'b1;
		idle(3);
		check({5'h0, sinks}, 8'h00);
		check({7'h0, fault_line}, 8'h00);
		sense.temp_above_shut = 1'b0;
		idle(20);
		check({7'h0, fault_line}, 8'h00);
		sense.temp_above_recover = 1'b0;
		idle(3);
		check({7'h0, fault_line}, 8'h01);
		check({7'h0, level < 8'h20}, 8'h01);
		wait_level(8'hff, 700);
		sense.temp_above_fold = 1'b1;
		sense.fold_steps = 4'h2;
		idle(3);
		check(level, 8'hdf);
		sense.temp_above_fold = 1'b0;
		// undervoltage lockout and its hysteresis
		sense.supply_above_on = 1'b0;
		sense.supply_above_off = 1'b0;
		idle(3);
		check({5'h0, sinks}, 8'h00);
		check({7'h0, fault_line}, 8'h00);
		sense.supply_above_off = 1'b1;
		idle(3);
		check({5'h0, sinks}, 8'h00);
		sense.temp_above_shut = 1'b1;
		sense.temp_above_recover = 1'b1;
		sense.supply_above_on = 1'b1;
		idle(3);
		check({7'h0, fault_line}, 8'h00);
		sense.temp_above_shut = 1'b0;
		sense.temp_above_recover = 1'b0;
		idle(3);
		check({7'h0, fault_line}, 8'h01);
		check({5'h0, sinks}, 8'h07);
		// standby entry, timer restart, exit
		dim_level = 3'h0;
		idle(190);
		check({7'h0, standby}, 8'h00);
		dim_level = 3'h2;
		idle(500);
		dim_level = 3'h0;
		idle(190);
		check({7'h0, standby}, 8'h00);
		idle(20);
		check({7'h0, standby}, 8'h01);
		dim_level = 3'h4;
		idle(2);
		check({4'h0, standby, sinks}, 8'h04);
		// open string under pulse dimming, hiccup retest
		dim_mask = 3'h1;
		open_det = 3'h1;
		pulse_en = 1'b1;
		wait_pulses(6);
		check({7'h0, fault_line}, 8'h01);
		wait_pulses(7);
		idle(10);
		check({4'h0, fault_line, sinks}, 8'h00);
		idle(3200);
		check({7'h0, fault_line}, 8'h00);
		open_det = 3'h0;
		wait_line(1'b1, 3300);
		pulse_en = 1'b0;
		// shorted string at full duty
		dim_level = 3'h7;
		sense.supply_above_short = 1'b1;
		idle(600);
		pin_hi = 3'h2;
		idle(250);
		check({7'h0, fault_line}, 8'h01);
		wait_line(1'b0, 80);
		idle(2);
		check({5'h0, sinks}, 8'h00);
		idle(3200);
		check({7'h0, fault_line}, 8'h00);
		pin_hi = 3'h0;
		wait_line(1'b1, 3300);
		idle(3);
		check({5'h0, sinks}, 8'h07);
		// deglitch timer clears on a gap
		pin_hi = 3'h2;
		idle(200);
		pin_hi = 3'h0;
		idle(5);
		pin_hi = 3'h2;
		idle(200);
		check({7'h0, fault_line}, 8'h01);
		// no short detection on a low supply
		sense.supply_above_short = 1'b0;
		idle(600);
		check({7'h0, fault_line}, 8'h01);
		pin_hi = 3'h0;
		// pulses below the minimum on-time must never be judged
		open_det = 3'h1;
		repeat (8) begin
			dim_level = 3'h0;
			idle(100);
			dim_level = 3'h1;
			idle(300);
		end
		check({7'h0, fault_line}, 8'h01);
		open_det = 3'h0;
		// reset in mid-run, then a clean restart
		dim_level = 3'h7;
		idle(20);
		reset_n = 1'b0;
		idle(2);
		check({4'h0, standby, sinks}, 8'h08);
		check({7'h0, f_oe}, 8'h00);
		reset_n = 1'b1;
		idle(3);
		check({4'h0, standby, sinks}, 8'h07);
		check({7'h0, fault_line}, 8'h01);
		close_out();
	end
endmodule : lspc_bench
